// ===== rtl/dsau_access_unit.sv
// Data-space access unit: address generation, byte/word steering, trap, extension.
// Assumes the core issues at most one request a cycle; the special registers sit outside.
`timescale 1ns/1ns
`default_nettype none
module dsau_access_unit (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire dsau_pkg::dsau_req_t req_in,
	input wire logic ext_valid_in,
	input wire dsau_pkg::dsau_ext_t ext_op_in,
	input wire logic [3:0] ext_sel_in,
	input wire logic [15:0] sfr_rdata_in,
	input wire logic [3:0] wreg_rd_sel_in,
	output dsau_pkg::dsau_sfr_bus_t sfr_bus_out,
	output logic sfr_rd_out,
	output logic [15:0] wreg_rd_data_out,
	output logic [15:0] effective_address_out,
	output logic [15:0] rdata_out,
	output logic done_out,
	output logic trap_out
);
	import dsau_pkg::*;

	logic [15:0] wreg_reg [wreg_count];
	logic [7:0] ram_low [ram_words];
	logic [7:0] ram_high [ram_words];
	logic [15:0] effective_address;
	logic misaligned;
	logic in_sfr;
	logic in_ram;
	logic sfr_implemented;
	logic [ram_index_width-1:0] ram_index;
	logic store_low;
	logic store_high;
	logic [15:0] ram_word;
	logic [15:0] fetched_word;
	logic [7:0] picked_byte;
	logic [15:0] load_value;
	logic [15:0] wdata_lanes;
	logic trap_pending_reg;
	logic [15:0] rdata_reg;
	logic done_reg;
	logic [15:0] ea_reg;

	always_comb begin
		unique case (req_in.mode)
			dsau_mode_near_direct: effective_address = {3'h0, req_in.direct_addr[near_field_width-1:0]};
			dsau_mode_wide_direct: effective_address = req_in.direct_addr;
			dsau_mode_indirect, dsau_mode_post_inc: effective_address = wreg_reg[req_in.pointer_sel];
		endcase
	end

	// Word-only operations are forced to word size regardless of the size bit
	logic is_byte;
	assign is_byte = req_in.byte_op & ~req_in.word_only;
	assign misaligned = req_in.valid & ~is_byte & effective_address[0];
	assign in_sfr = effective_address <= sfr_window_last;
	// Space between the RAM and the top of the near region reads zero and drops writes
	assign in_ram = ~in_sfr && effective_address <= near_region_last
		&& (effective_address - 16'(ram_base)) < 16'(2 * ram_words);
	// The map is fixed per build: a region left out reads zero even if a peripheral sits there
	assign sfr_implemented = sfr_region_map[effective_address[10:5]];
	assign ram_index = ram_index_width'((effective_address - 16'(ram_base)) >> 1);

	// Lane steering: a byte goes to the half its address picks, a word spans both
	assign wdata_lanes = is_byte ? {req_in.wdata[7:0], req_in.wdata[7:0]} : req_in.wdata;
	assign store_low = req_in.valid & req_in.write & ~misaligned & (~is_byte | ~effective_address[0]);
	assign store_high = req_in.valid & req_in.write & ~misaligned & (~is_byte | effective_address[0]);

	always_ff @(posedge clock_in) begin
		if (in_ram && store_low) begin
			ram_low[ram_index] <= wdata_lanes[7:0];
		end
		if (in_ram && store_high) begin
			ram_high[ram_index] <= wdata_lanes[15:8];
		end
	end

	assign ram_word = {ram_high[ram_index], ram_low[ram_index]};

	always_comb begin
		sfr_bus_out.word_addr = effective_address[15:1];
		sfr_bus_out.write_low = in_sfr & sfr_implemented & store_low;
		sfr_bus_out.write_high = in_sfr & sfr_implemented & store_high;
		sfr_bus_out.wdata = wdata_lanes;
	end
	assign sfr_rd_out = req_in.valid & ~req_in.write & in_sfr & sfr_implemented;

	always_comb begin
		if (in_sfr) begin
			fetched_word = sfr_implemented ? sfr_rdata_in : 16'h0000;
		end else if (in_ram) begin
			fetched_word = ram_word;
		end else begin
			fetched_word = 16'h0000;
		end
	end
	assign picked_byte = effective_address[0] ? fetched_word[15:8] : fetched_word[7:0];
	assign load_value = is_byte ? {8'h00, picked_byte} : fetched_word;

	// Reads complete even when misaligned so the instruction finishes in the same cycle its trap is reported
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_reg <= 16'h0000;
			done_reg <= 1'b0;
			ea_reg <= 16'h0000;
		end else begin
			done_reg <= req_in.valid;
			ea_reg <= effective_address;
			if (req_in.valid && !req_in.write) begin
				rdata_reg <= load_value;
			end
		end
	end

	// The trap lags the access by one cycle, so the core sees it in the same cycle as done for the finished instruction
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			trap_pending_reg <= 1'b0;
		end else begin
			trap_pending_reg <= misaligned;
		end
	end

	// Working registers: pointer update, byte loads and the extension operations
	genvar gi;
	generate
		for (gi = 0; gi < wreg_count; gi++) begin : g_wreg
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					wreg_reg[gi] <= 16'h0000;
				end else if (ext_valid_in && ext_sel_in == 4'(gi) && ext_op_in == dsau_ext_sign) begin
					wreg_reg[gi] <= {{8{wreg_reg[gi][7]}}, wreg_reg[gi][7:0]};
				end else if (ext_valid_in && ext_sel_in == 4'(gi) && ext_op_in == dsau_ext_zero) begin
					wreg_reg[gi] <= {8'h00, wreg_reg[gi][7:0]};
				end else if (req_in.valid && !req_in.write && req_in.dest_sel == 4'(gi)) begin
					if (is_byte) begin
						wreg_reg[gi] <= {wreg_reg[gi][15:8], picked_byte};
					end else begin
						wreg_reg[gi] <= fetched_word;
					end
				end else if (req_in.valid && req_in.mode == dsau_mode_post_inc && req_in.pointer_sel == 4'(gi)) begin
					wreg_reg[gi] <= wreg_reg[gi] + (is_byte ? byte_step : word_step);
				end
			end
		end
	endgenerate

	assign wreg_rd_data_out = wreg_reg[wreg_rd_sel_in];
	assign effective_address_out = ea_reg;
	assign rdata_out = rdata_reg;
	assign done_out = done_reg;
	assign trap_out = trap_pending_reg;

	// A faulting access is one step and its report the next; both fault kinds share the report
	sequence s_odd_word_read;
		req_in.valid && !req_in.write && !is_byte && effective_address[0];
	endsequence

	sequence s_odd_word_write;
		req_in.valid && req_in.write && !is_byte && effective_address[0];
	endsequence

	sequence s_fault_reported;
		done_out && trap_out;
	endsequence

	property p_trap_after_odd_word;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && !is_byte && effective_address[0]) |=> trap_out;
	endproperty
	a_trap_after_odd_word: assert property (p_trap_after_odd_word) else $error("odd word access did not trap");

	property p_no_trap_aligned;
		@(posedge clock_in) disable iff (rst_in)
		!(req_in.valid && !is_byte && effective_address[0]) |=> !trap_out;
	endproperty
	a_no_trap_aligned: assert property (p_no_trap_aligned) else $error("trap without cause");

	property p_write_suppressed;
		@(posedge clock_in) disable iff (rst_in)
		misaligned |-> !sfr_bus_out.write_low && !sfr_bus_out.write_high && !store_low && !store_high;
	endproperty
	a_write_suppressed: assert property (p_write_suppressed) else $error("faulting write stored");

	property p_read_completes;
		@(posedge clock_in) disable iff (rst_in)
		s_odd_word_read |=> s_fault_reported;
	endproperty
	a_read_completes: assert property (p_read_completes) else $error("faulting read did not complete");

	property p_byte_single_strobe;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && req_in.write && is_byte) |-> !(store_low && store_high) && (store_high == effective_address[0]);
	endproperty
	a_byte_single_strobe: assert property (p_byte_single_strobe) else $error("byte write wrong strobe");

	property p_word_both_strobes;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && req_in.write && !is_byte && !effective_address[0]) |-> store_low && store_high;
	endproperty
	a_word_both_strobes: assert property (p_word_both_strobes) else $error("word write missing strobe");

	property p_post_inc_step;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && req_in.mode == dsau_mode_post_inc && (req_in.write || req_in.dest_sel != req_in.pointer_sel)
			&& !(ext_valid_in && ext_sel_in == req_in.pointer_sel))
		|=> wreg_reg[$past(req_in.pointer_sel)] == $past(effective_address) + ($past(is_byte) ? 16'h0001 : 16'h0002);
	endproperty
	a_post_inc_step: assert property (p_post_inc_step) else $error("pointer step wrong");

	property p_unimpl_sfr_zero;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && !req_in.write && in_sfr && !sfr_implemented) |=> rdata_out == 16'h0000;
	endproperty
	a_unimpl_sfr_zero: assert property (p_unimpl_sfr_zero) else $error("unimplemented address nonzero");

	property p_byte_low_lanes;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && !req_in.write && is_byte) |=> rdata_out[15:8] == 8'h00;
	endproperty
	a_byte_low_lanes: assert property (p_byte_low_lanes) else $error("byte not on low lane");

	property p_write_fault_reported;
		@(posedge clock_in) disable iff (rst_in)
		s_odd_word_write |=> s_fault_reported;
	endproperty
	a_write_fault_reported: assert property (p_write_fault_reported) else $error("faulting write unreported");

	property p_done_each_request;
		@(posedge clock_in) disable iff (rst_in)
		req_in.valid |=> done_out;
	endproperty
	a_done_each_request: assert property (p_done_each_request) else $error("request without done");

	property p_no_done_idle;
		@(posedge clock_in) disable iff (rst_in)
		!req_in.valid |=> !done_out;
	endproperty
	a_no_done_idle: assert property (p_no_done_idle) else $error("done without request");

	property p_byte_load_keeps_high;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && !req_in.write && is_byte && !(ext_valid_in && ext_sel_in == req_in.dest_sel))
		|=> wreg_reg[$past(req_in.dest_sel)] == {$past(wreg_reg[req_in.dest_sel][15:8]), $past(picked_byte)};
	endproperty
	a_byte_load_keeps_high: assert property (p_byte_load_keeps_high) else $error("byte load hit high byte");

	property p_sign_extend;
		@(posedge clock_in) disable iff (rst_in)
		(ext_valid_in && ext_op_in == dsau_ext_sign)
		|=> wreg_reg[$past(ext_sel_in)] == {{8{$past(wreg_reg[ext_sel_in][7])}}, $past(wreg_reg[ext_sel_in][7:0])};
	endproperty
	a_sign_extend: assert property (p_sign_extend) else $error("sign extend wrong");

	property p_zero_extend;
		@(posedge clock_in) disable iff (rst_in)
		(ext_valid_in && ext_op_in == dsau_ext_zero)
		|=> wreg_reg[$past(ext_sel_in)] == {8'h00, $past(wreg_reg[ext_sel_in][7:0])};
	endproperty
	a_zero_extend: assert property (p_zero_extend) else $error("zero extend wrong");

	property p_near_direct_reach;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && req_in.mode == dsau_mode_near_direct) |-> effective_address <= near_region_last;
	endproperty
	a_near_direct_reach: assert property (p_near_direct_reach) else $error("near address out of region");

	property p_sfr_strobe_window;
		@(posedge clock_in) disable iff (rst_in)
		(sfr_bus_out.write_low || sfr_bus_out.write_high || sfr_rd_out) |-> (in_sfr && sfr_implemented);
	endproperty
	a_sfr_strobe_window: assert property (p_sfr_strobe_window) else $error("special bus used off map");

	property p_outside_reads_zero;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && !req_in.write && !in_sfr && !in_ram) |=> rdata_out == 16'h0000;
	endproperty
	a_outside_reads_zero: assert property (p_outside_reads_zero) else $error("empty space read nonzero");

	property p_word_read_pairs;
		@(posedge clock_in) disable iff (rst_in)
		(req_in.valid && !req_in.write && !is_byte && !effective_address[0] && in_ram) |=> rdata_out == $past(ram_word);
	endproperty
	a_word_read_pairs: assert property (p_word_read_pairs) else $error("word read lanes wrong");
endmodule
`default_nettype wire

// ===== rtl/dsau_pkg.sv
// Constants and carrier types of the data-space access unit.
// Assumes a 16-bit byte-addressed data space and one system clock.
package dsau_pkg;
	localparam int unsigned addr_width = 16;
	localparam int unsigned data_width = 16;
	localparam logic [15:0] near_region_last = 16'h1fff;
	localparam int unsigned near_field_width = 13;
	localparam logic [15:0] sfr_window_last = 16'h07ff;
	localparam int unsigned sfr_region_bytes = 32;
	localparam int unsigned sfr_region_count = 64;
	localparam int unsigned ram_base = 16'h0800;
	localparam int unsigned ram_words = 512;
	localparam int unsigned ram_index_width = 9;
	localparam logic [15:0] byte_step = 16'h0001;
	localparam logic [15:0] word_step = 16'h0002;
	localparam int unsigned wreg_count = 16;
	// One bit per 32-byte region of the special register window; system and memory-control regions fitted
	localparam logic [63:0] sfr_region_map = 64'h0c00_0000_0000_0000;

	typedef enum logic [1:0] {
		dsau_mode_indirect = 2'b00,
		dsau_mode_post_inc = 2'b01,
		dsau_mode_near_direct = 2'b10,
		dsau_mode_wide_direct = 2'b11
	} dsau_mode_t;

	typedef enum logic [1:0] {
		dsau_ext_none = 2'b00,
		dsau_ext_sign = 2'b01,
		dsau_ext_zero = 2'b10
	} dsau_ext_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic byte_op;
		logic word_only;
		dsau_mode_t mode;
		logic [3:0] pointer_sel;
		logic [3:0] dest_sel;
		logic [15:0] direct_addr;
		logic [15:0] wdata;
	} dsau_req_t;

	typedef struct packed {
		logic [14:0] word_addr;
		logic write_low;
		logic write_high;
		logic [15:0] wdata;
	} dsau_sfr_bus_t;
endpackage

// ===== dv/dsau_far_model.sv
// Far-side model of the special register bus: a byte-laned word store behind the fitted regions.
// Assumes one system clock and only the two fitted 32-byte regions, told apart by word address bit 4.
`timescale 1ns/1ns
`default_nettype none
module dsau_far_model (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire dsau_pkg::dsau_sfr_bus_t sfr_bus_in,
	input wire logic sfr_rd_in,
	output logic [15:0] sfr_rdata_out
);
	logic [15:0] noise_reg;
	logic [7:0] lane_low_reg [32];
	logic [7:0] lane_high_reg [32];
	// Unread data keeps changing so a stale value never passes for a real read
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			noise_reg <= 16'h5a3c;
		end else begin
			noise_reg <= ~noise_reg ^ 16'h0101;
		end
	end
	// Each lane has its own strobe over one shared word index
	always_ff @(posedge clock_in) begin
		if (sfr_bus_in.write_low) begin
			lane_low_reg[sfr_bus_in.word_addr[4:0]] <= sfr_bus_in.wdata[7:0];
		end
		if (sfr_bus_in.write_high) begin
			lane_high_reg[sfr_bus_in.word_addr[4:0]] <= sfr_bus_in.wdata[15:8];
		end
	end
	assign sfr_rdata_out = sfr_rd_in ? {lane_high_reg[sfr_bus_in.word_addr[4:0]], lane_low_reg[sfr_bus_in.word_addr[4:0]]}
		: noise_reg;
endmodule
`default_nettype wire

// ===== dv/test_data_space_access_unit.sv
// Self-checking bench of the data-space access unit.
// Assumes RAM at 0x0800 and fitted special regions at 0x0740 and 0x0760 only.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("ERROR %0t: got %h want %h", $time, a, e); end end
module test_data_space_access_unit;
	import dsau_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	dsau_req_t req = '0;
	logic ext_valid = 1'b0;
	dsau_ext_t ext_op = dsau_ext_none;
	logic [3:0] ext_sel = 4'h0;
	logic [3:0] rd_sel = 4'h0;
	logic [15:0] sfr_rdata, wreg_data, ea, rdata;
	dsau_sfr_bus_t sfr_bus, bus;
	logic sfr_rd, done, trap, lo, hi, rd;
	int errors = 0;
	int checked = 0;
	dsau_access_unit u_dut (.clock_in(clock), .rst_in(rst), .req_in(req), .ext_valid_in(ext_valid),
		.ext_op_in(ext_op), .ext_sel_in(ext_sel), .sfr_rdata_in(sfr_rdata), .wreg_rd_sel_in(rd_sel),
		.sfr_bus_out(sfr_bus), .sfr_rd_out(sfr_rd), .wreg_rd_data_out(wreg_data),
		.effective_address_out(ea), .rdata_out(rdata), .done_out(done), .trap_out(trap));
	dsau_far_model u_far (.clock_in(clock), .rst_in(rst), .sfr_bus_in(sfr_bus), .sfr_rd_in(sfr_rd),
		.sfr_rdata_out(sfr_rdata));
	initial begin
		forever #20 clock = ~clock;
	end
	// One access, strobes caught mid-cycle, answer left standing on return
	task automatic go(input logic w, bt, wo, dsau_mode_t m, input logic [3:0] p, d, input logic [15:0] a, wd);
		@(posedge clock);
		#1 req = '{1'b1, w, bt, wo, m, p, d, a, wd};
		@(negedge clock);
		lo = sfr_bus.write_low;
		hi = sfr_bus.write_high;
		rd = sfr_rd;
		bus = sfr_bus;
		@(posedge clock);
		#1 req.valid = 1'b0;
		`CHK(done, 1'b1)
	endtask
	task automatic ext(input dsau_ext_t op, input logic [3:0] s);
		@(posedge clock);
		#1 ext_valid = 1'b1;
		ext_op = op;
		ext_sel = s;
		@(posedge clock);
		#1 ext_valid = 1'b0;
	endtask
	task automatic wr(input logic [3:0] s, input logic [15:0] e);
		rd_sel = s;
		#1 `CHK(wreg_data, e)
	endtask
	task automatic t_word;
		go(1, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h0800, 16'hbeef);
		`CHK({lo, hi, rd}, 3'b000)
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h1, 16'h0800, 16'h0000);
		`CHK(rdata, 16'hbeef)
		go(1, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h0740, 16'hcafe);
		`CHK({lo, hi}, 2'b11)
		`CHK({bus.word_addr, bus.wdata}, {15'h03a0, 16'hcafe})
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h8, 16'h0740, 16'h0000);
		`CHK({rd, rdata}, {1'b1, 16'hcafe})
	endtask
	task automatic t_byte;
		go(1, 1, 0, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h0741, 16'h1212);
		`CHK({lo, hi, bus.wdata}, {2'b01, 16'h1212})
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h8, 16'h0740, 16'h0000);
		`CHK(rdata, 16'h12fe)
		go(1, 1, 0, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h0801, 16'h1212);
		`CHK({lo, hi, rd}, 3'b000)
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h3, 16'h0800, 16'h0000);
		`CHK(rdata, 16'h12ef)
		go(0, 1, 0, dsau_mode_wide_direct, 4'h0, 4'h1, 16'h0801, 16'h0000);
		`CHK(rdata, 16'h0012)
		wr(4'h1, 16'hbe12);
		go(0, 1, 0, dsau_mode_wide_direct, 4'h0, 4'h4, 16'h0800, 16'h0000);
		wr(4'h4, 16'h00ef);
		go(0, 1, 1, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h0800, 16'h0000);
		`CHK(rdata, 16'h12ef)
	endtask
	task automatic t_ext;
		ext(dsau_ext_sign, 4'h4);
		wr(4'h4, 16'hffef);
		ext(dsau_ext_sign, 4'h1);
		wr(4'h1, 16'h0012);
		ext(dsau_ext_zero, 4'h3);
		wr(4'h3, 16'h00ef);
	endtask
	task automatic t_trap;
		go(1, 0, 0, dsau_mode_near_direct, 4'h0, 4'h0, 16'he802, 16'h0802);
		`CHK(trap, 1'b0)
		go(1, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h0803, 16'h1111);
		`CHK({lo, hi, trap}, 3'b001)
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h5, 16'h0803, 16'h0000);
		`CHK({trap, ea}, {1'b1, 16'h0803})
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h2, 16'h0802, 16'h0000);
		`CHK({trap, rdata}, {1'b0, 16'h0802})
	endtask
	task automatic t_post;
		go(0, 0, 0, dsau_mode_post_inc, 4'h2, 4'h6, 16'h0000, 16'h0000);
		`CHK({ea, rdata}, {16'h0802, 16'h0802})
		wr(4'h2, 16'h0804);
		go(1, 1, 0, dsau_mode_post_inc, 4'h2, 4'h6, 16'h0000, 16'h5555);
		`CHK(ea, 16'h0804)
		wr(4'h2, 16'h0805);
		go(0, 0, 0, dsau_mode_indirect, 4'h2, 4'h7, 16'h0000, 16'h0000);
		`CHK(trap, 1'b1)
		`CHK(rdata[7:0], 8'h55)
	endtask
	task automatic t_sfr;
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h7, 16'h0100, 16'h0000);
		`CHK({rd, rdata}, {1'b0, 16'h0000})
		go(1, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h0, 16'h07e0, 16'hffff);
		`CHK({lo, hi, trap}, 3'b000)
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h8, 16'h0740, 16'h0000);
		`CHK({rd, rdata}, {1'b1, 16'h12fe})
		go(0, 0, 0, dsau_mode_wide_direct, 4'h0, 4'h7, 16'h2000, 16'h0000);
		`CHK({rd, rdata}, {1'b0, 16'h0000})
		wr(4'h7, 16'h0000);
	endtask
	task automatic end_of_test;
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		t_word();
		t_byte();
		t_ext();
		t_trap();
		t_post();
		t_sfr();
		end_of_test();
	end
	initial begin
		repeat (2000) @(posedge clock);
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
